// File: verilog/spw_power_ctrl.v
`timescale 1ns/100ps
`include "spw_map.vh"
// Behaviour
// - Falling edge on power switch input drives supply request low.
// - Keyboard, mouse or serial receive activity also asserts supply request.
// - Supply request both powers up and releases supply for standby.
// - Supply request pin defaults to open-collector power output after reset.
// - Switch pin defaults to switch input after reset.
// - Reassigned pins act as bidirectional general purpose I/O bits.
module spw_power_ctrl #(
  parameter NWAKE = `SPW_WAKE_SRCS
) (
  // Clock and reset, trickle_supply domain
  input wire sys_clk,
  input wire nrst,
  // Power switch / general_io_pin_a pin
  input wire general_io_pin_a_in,
  output wire general_io_pin_a_out,
  output wire general_io_pin_a_oe,
  // Supply request / general_io_pin_b pin, open collector in its power role, driven both ways as general I/O
  input wire general_io_pin_b_in,
  output wire general_io_pin_b_out,
  output wire general_io_pin_b_oe,
  // Wakeup activity: keyboard, mouse, serial receive
  input wire [NWAKE-1:0] wake_evt,
  // Software control
  input wire power_off_cmd,
  input wire pin_a_gpio_sel,
  input wire pin_b_gpio_sel,
  input wire gpio_a_dout,
  input wire gpio_a_dir_out,
  input wire gpio_b_dout,
  input wire gpio_b_dir_out,
  // Status
  output reg gpio_a_din_ff,
  output reg gpio_b_din_ff,
  output reg supply_on_ff
);
  // Everything here runs from the trickle_supply domain, so it keeps
  // watching the switch and the wakeups while the main supply is off.

  // Synchronised pin and wakeup levels
  wire [1:0] pins_sync;
  wire [NWAKE-1:0] wake_sync;
  wire switch_level;
  wire req_pin_level;

  // Edge detectors
  reg button_prev_ff;
  reg off_prev_ff;
  wire [NWAKE-1:0] wake_rise;
  wire button_fall;
  wire wake_any;
  wire off_rise;

  // Supply state
  reg nxt_supply_on;
  wire power_on_evt;
  wire supply_on_request_n;

  // Pin function decode and drive
  wire pin_a_is_power;
  wire pin_b_is_power;
  reg drive_a_out;
  reg drive_a_oe;
  reg drive_b_out;
  reg drive_b_oe;

  // Supply states; one bit, so the state register is the request itself
  localparam [0:0] ST_OFF = `SPW_ST_OFF;
  localparam [0:0] ST_ON = `SPW_ST_ON;

  // All pin-side inputs cross two flops first. The synchroniser resets
  // high, which is the idle level of both pins but not of the wakeups,
  // so the wakeup history below must reset high as well.
  spw_sync #(.W(NWAKE + 2)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d_in({wake_evt, general_io_pin_b_in, general_io_pin_a_in}),
    .q_out({wake_sync, pins_sync})
  );

  // Name the synchronised pin levels
  assign switch_level = pins_sync[0];
  assign req_pin_level = pins_sync[1];

  // Function select decode; select low is the power role
  assign pin_a_is_power = (pin_a_gpio_sel == `SPW_FN_POWER);
  assign pin_b_is_power = (pin_b_gpio_sel == `SPW_FN_POWER);

  // One rising-edge detector per wakeup source, so a second source
  // still wakes while the first is held. The history resets high
  // because the synchroniser does: leaving reset must not look like
  // activity on every source at once.
  genvar gi;
  generate
    for (gi = 0; gi < NWAKE; gi = gi + 1) begin : g_wake
      reg prev_ff;
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          prev_ff <= `SPW_WAKE_HIST_RST;
        end else begin
          prev_ff <= wake_sync[gi];
        end
      end
      assign wake_rise[gi] = wake_sync[gi] && !prev_ff;
    end
  endgenerate

  // Wakeup from any source
  assign wake_any = |wake_rise;

  // Switch edge only counts while the pin is in its power role; a
  // general I/O bit toggling low must not start the supply
  assign button_fall = pin_a_is_power && button_prev_ff && !switch_level;

  // Any cause that powers the system up
  assign power_on_evt = button_fall || wake_any;

  // Edge of the command, so a held command cannot fight a later wakeup
  assign off_rise = power_off_cmd && !off_prev_ff;

  // Supply state: a wakeup beats an off command in the same cycle, so a
  // press racing a software shutdown never leaves the machine dark
  always @* begin
    nxt_supply_on = supply_on_ff;
    case (supply_on_ff)
      ST_OFF: begin
        if (power_on_evt) begin
          nxt_supply_on = ST_ON;
        end
      end
      ST_ON: begin
        if (off_rise && !power_on_evt) begin
          nxt_supply_on = ST_OFF;
        end
      end
      default: begin
        nxt_supply_on = ST_OFF;
      end
    endcase
  end

  // Supply state register; off out of reset so a cold start stays dark
  // until a press or a wakeup arrives
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      supply_on_ff <= ST_OFF;
    end else begin
      supply_on_ff <= nxt_supply_on;
    end
  end

  // Switch history starts at the pull-up level, so no false press
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      button_prev_ff <= `SPW_SWITCH_IDLE;
    end else begin
      button_prev_ff <= switch_level;
    end
  end

  // Command history starts idle; a command already high at release
  // reads as a rise, harmless since the supply starts off anyway
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      off_prev_ff <= `SPW_OFF_IDLE;
    end else begin
      off_prev_ff <= power_off_cmd;
    end
  end

  // Registered level of pin A for software reads
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gpio_a_din_ff <= `SPW_DIN_RST;
    end else begin
      gpio_a_din_ff <= switch_level;
    end
  end

  // Registered level of pin B for software reads
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gpio_b_din_ff <= `SPW_DIN_RST;
    end else begin
      gpio_b_din_ff <= req_pin_level;
    end
  end

  // Request level as it would stand on an active-low pin
  assign supply_on_request_n = ~supply_on_ff;

  // Pin A: an input only in its switch role, so the panel switch and
  // its pull-up own the line; general I/O drives when set as output
  always @* begin
    drive_a_out = gpio_a_dout;
    drive_a_oe = `SPW_OE_OFF;
    if (pin_a_gpio_sel == `SPW_FN_GPIO) begin
      drive_a_oe = gpio_a_dir_out;
    end
  end

  // Pin B: open collector in its power role, pulling low only while the
  // supply is requested and floating otherwise, so the supply's own
  // pull-up turns it off even when this domain is not driving
  always @* begin
    if (pin_b_is_power) begin
      drive_b_out = `SPW_OC_LOW;
      drive_b_oe = !supply_on_request_n;
    end else begin
      drive_b_out = gpio_b_dout;
      drive_b_oe = gpio_b_dir_out;
    end
  end

  // Pin drivers
  assign general_io_pin_a_out = drive_a_out;
  assign general_io_pin_a_oe = drive_a_oe;
  assign general_io_pin_b_out = drive_b_out;
  assign general_io_pin_b_oe = drive_b_oe;
endmodule // spw_power_ctrl

// File: verilog/spw_map.vh
`ifndef SPW_MAP_VH
`define SPW_MAP_VH
// Pin function select: power function or general purpose I/O
`define SPW_FN_POWER 1'b0
`define SPW_FN_GPIO 1'b1
// Supply states, one bit wide
`define SPW_ST_OFF 1'b0
`define SPW_ST_ON 1'b1
// Wakeup source count
`define SPW_WAKE_SRCS 3
// Reset and idle levels
`define SPW_SYNC_RST 1'b1
`define SPW_SWITCH_IDLE 1'b1
`define SPW_WAKE_HIST_RST 1'b1
`define SPW_OFF_IDLE 1'b0
`define SPW_DIN_RST 1'b0
// Pin drive levels
`define SPW_OE_OFF 1'b0
`define SPW_OC_LOW 1'b0
`endif

// File: verilog/spw_sync.v
`timescale 1ns/100ps
`include "spw_map.vh"
// Two-flop synchroniser, one per bit
module spw_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Data
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // First stage feeds only the second
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= {W{`SPW_SYNC_RST}}; // Pull-up level of the pins
      sync_ff <= {W{`SPW_SYNC_RST}};
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end
  assign q_out = sync_ff;
endmodule // spw_sync

// File: sim/spw_power_ctrl_monitor.sv
`timescale 1ns/100ps
// Supply state and pin checks, trickle domain
module spw_pwr_monitor #(
  parameter NWAKE = 3
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Pins
  input wire general_io_pin_a_in,
  input wire general_io_pin_a_out,
  input wire general_io_pin_a_oe,
  input wire general_io_pin_b_out,
  input wire general_io_pin_b_oe,
  // Controls
  input wire [NWAKE-1:0] wake_evt,
  input wire power_off_cmd,
  input wire pin_a_gpio_sel,
  input wire pin_b_gpio_sel,
  input wire gpio_a_dout,
  input wire gpio_a_dir_out,
  input wire gpio_b_dout,
  input wire gpio_b_dir_out,
  // State
  input wire supply_on_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_press_wakes: assert property (
    $fell(general_io_pin_a_in) && !pin_a_gpio_sel |-> ##[1:4] supply_on_ff) else $error("no on");
  a_event_wakes: assert property (
    $rose(|wake_evt) |-> ##[1:4] supply_on_ff) else $error("no wake");
  a_off_releases: assert property (
    $rose(power_off_cmd) && $stable(wake_evt) && $past(wake_evt, 2) == $past(wake_evt, 3)
    && !($past(general_io_pin_a_in, 3) && !$past(general_io_pin_a_in, 2))
    |=> !supply_on_ff) else $error("no off");
  a_on_holds: assert property (
    supply_on_ff && !$rose(power_off_cmd) |=> supply_on_ff) else $error("dropped");
  a_req_pin: assert property (
    !pin_b_gpio_sel |-> general_io_pin_b_oe == supply_on_ff && !general_io_pin_b_out)
    else $error("bad request pin");
  a_switch_in: assert property (
    !pin_a_gpio_sel |-> !general_io_pin_a_oe) else $error("switch pin driven");
  a_gpio_a: assert property (
    pin_a_gpio_sel |-> general_io_pin_a_oe == gpio_a_dir_out
    && general_io_pin_a_out == gpio_a_dout) else $error("bad gpio a");
  a_gpio_b: assert property (
    pin_b_gpio_sel |-> general_io_pin_b_oe == gpio_b_dir_out
    && general_io_pin_b_out == gpio_b_dout) else $error("bad gpio b");
  c_on: cover property ($rose(supply_on_ff));
  c_off: cover property ($fell(supply_on_ff));
  c_gpio: cover property (pin_b_gpio_sel && general_io_pin_b_oe);
endmodule // spw_pwr_monitor
bind spw_power_ctrl spw_pwr_monitor #(.NWAKE(NWAKE)) mon_u (.*);

// File: sim/spw_psu_model.sv
`timescale 1ns/100ps
// Supply with pulled-up on/off input; panel switch to ground
module spw_psu_model (
  // Device drive
  input wire a_oe,
  input wire a_o,
  input wire b_oe,
  input wire b_o,
  // Panel switch
  input wire press,
  // Pin levels, supply state
  output wire a_pin,
  output wire b_pin,
  output wire supply_up
);
  // Pull-ups win only while nobody drives
  assign a_pin = a_oe ? a_o : !press;
  assign b_pin = b_oe ? b_o : 1'b1;
  assign supply_up = !b_pin;
endmodule // spw_psu_model

// File: sim/spw_power_ctrl_tb.sv
`timescale 1ns/100ps
module spw_power_ctrl_tb;
  reg sys_clk = 0, nrst = 0, press = 0, off = 0, sa = 0, sb = 0, ad = 0, ao = 0;
  reg bd = 0, bo = 0;
  reg [2:0] wk = 3'h0;
  reg [31:0] rs = 32'hbdf5928e;
  integer bad_count = 0, n_compared = 0, cyc = 0, i;
  wire a_in, b_in, a_o, a_oe, b_o, b_oe, da, db, sup, up;
  spw_power_ctrl dut_u (.sys_clk(sys_clk), .nrst(nrst), .general_io_pin_a_in(a_in),
    .general_io_pin_a_out(a_o), .general_io_pin_a_oe(a_oe), .general_io_pin_b_in(b_in),
    .general_io_pin_b_out(b_o), .general_io_pin_b_oe(b_oe), .wake_evt(wk),
    .power_off_cmd(off), .pin_a_gpio_sel(sa), .pin_b_gpio_sel(sb), .gpio_a_dout(ad),
    .gpio_a_dir_out(ao), .gpio_b_dout(bd), .gpio_b_dir_out(bo), .gpio_a_din_ff(da),
    .gpio_b_din_ff(db), .supply_on_ff(sup));
  spw_psu_model psu_u (.a_oe(a_oe), .a_o(a_o), .b_oe(b_oe), .b_o(b_o), .press(press),
    .a_pin(a_in), .b_pin(b_in), .supply_up(up));
  // Clock; ceiling well above the run
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc == 3000) begin
    bad_count++;
    give_verdict;
  end
  task chk(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %b exp %b", $time, g, e);
    end
  endtask
  // Inputs always move 2 ns after the edge
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  function [31:0] xs(input [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // Level a pin shows: driven value in output role, else its pull-up
  function pin_exp(input sel, input dir, input dout);
    pin_exp = (sel && dir) ? dout : 1'b1;
  endfunction
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(12);
    nrst = 1;
    tick(1);
    chk(b_oe, 0);
    chk(a_oe, 0);
    press = 1;
    tick(4);
    chk(up, 1);
    {press, off} = 2'h1;
    tick(2);
    chk(up, 0);
    off = 0;
    for (i = 0; i < 3; i++) begin
      wk = 3'h1 << i;
      tick(4);
      chk(sup, 1);
      off = 1;
      tick(2);
      chk(sup, 0);
      {wk, off} = 4'h0;
      tick(4);
    end
    // Mid-run reset with supply on; a wakeup held across release is no new edge
    wk = 3'h2;
    tick(4);
    chk(sup, 1);
    nrst = 0;
    tick(1);
    chk(b_oe, 0);
    nrst = 1;
    tick(4);
    chk(sup, 0);
    wk = 3'h0;
    tick(4);
    // Random pin modes; supply must stay off
    for (i = 0; i < 16; i++) begin
      rs = xs(rs);
      {sa, sb, ad, ao, bd, bo} = rs[5:0];
      tick(4);
      chk(a_in, pin_exp(sa, ao, ad));
      chk(b_in, pin_exp(sb, bo, bd));
      chk(da, a_in);
      chk(db, b_in);
      chk(sup, 0);
    end
    give_verdict;
  end
endmodule // spw_power_ctrl_tb
